// [design/pswc_sleep_ctrl.sv]
// Processor sleep entry and wake-up controller with register front end
`timescale 1ns/100ps
`include "pswc_cfg.svh"
module pswc_sleep_ctrl #(
    parameter int AW = `PSWC_ADDR_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pswc_pkg::pswc_core_req_t coreReq,
    input wire pswc_pkg::pswc_exc_t excIn,
    input wire logic priorityMaskBit,
    input wire logic faultMaskBit,
    output pswc_pkg::pswc_pwr_t pwr,
    output logic issueHold,
    output logic entryHold
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    pswc_pkg::pswc_state_t state;
    pswc_pkg::pswc_state_t next_state;
    logic deepSleepSelect;
    logic sleepOnExitEnable;
    logic pendToEventEnable;
    logic deepLatched;
    logic next_deep;
    logic wrEn;
    logic [AW-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [31:0] rdValue;
    logic evtQ;
    logic evtSet;
    logic evtClr;
    logic intWake;
    logic maskedWake;
    logic pendEvt;

    // Address match helper, shared by read and write decode
    function automatic logic isOff(input logic [AW-1:0] a, input logic [AW-1:0] off);
        return a == off;
    endfunction

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    pswc_axil_slave #(
        .AW(AW)
    ) u_bus (
        .mclk(mclk),
        .rst(rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(isOff(wrAddr, `PSWC_CTRL_OFF) || isOff(wrAddr, `PSWC_STAT_OFF)),
        .rdValue(rdValue),
        .rdOk(isOff(araddr, `PSWC_CTRL_OFF) || isOff(araddr, `PSWC_STAT_OFF))
    );

    // Control register: mode bits steering entry and wake
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            deepSleepSelect <= `PSWC_CTRL_RST;
            sleepOnExitEnable <= `PSWC_CTRL_RST;
            pendToEventEnable <= `PSWC_CTRL_RST;
        end else if (wrEn && wrStrb[0] && isOff(wrAddr, `PSWC_CTRL_OFF)) begin
            deepSleepSelect <= wrData[`PSWC_CTRL_DEEP_BIT];
            sleepOnExitEnable <= wrData[`PSWC_CTRL_EXIT_BIT];
            pendToEventEnable <= wrData[`PSWC_CTRL_PEND_BIT];
        end
    end

    // Read mux; the event latch is deliberately absent from it
    always_comb begin
        rdValue = 32'h0000_0000;
        if (isOff(araddr, `PSWC_CTRL_OFF)) begin
            rdValue[`PSWC_CTRL_DEEP_BIT] = deepSleepSelect;
            rdValue[`PSWC_CTRL_EXIT_BIT] = sleepOnExitEnable;
            rdValue[`PSWC_CTRL_PEND_BIT] = pendToEventEnable;
        end else if (isOff(araddr, `PSWC_STAT_OFF)) begin
            rdValue[`PSWC_STAT_SLEEP_BIT] = issueHold;
            rdValue[`PSWC_STAT_DEEP_BIT] = deepLatched;
            rdValue[`PSWC_STAT_HOLD_BIT] = entryHold;
        end
    end

    // ----------------------------------------------------------------
    // Event latch
    // ----------------------------------------------------------------
    // A pending interrupt counts as an event only with the option on
    assign pendEvt = excIn.newPend && pendToEventEnable;
    assign evtSet = coreReq.sendEventInstr || pendEvt;
    // Consumed by a skipping wait-for-event or by waking from event sleep
    assign evtClr = (state == pswc_pkg::RUN && coreReq.waitForEventInstr && evtQ)
        || (state == pswc_pkg::DOZE_EVT && evtQ);

    pswc_event_latch u_evt (
        .mclk(mclk),
        .rst(rst),
        .setEvt(evtSet),
        .clrEvt(evtClr),
        .evtQ(evtQ)
    );

    // ----------------------------------------------------------------
    // Wake conditions
    // ----------------------------------------------------------------
    // Masked higher interrupt wakes the core but handler entry waits
    assign maskedWake = excIn.irqHigher && priorityMaskBit && !faultMaskBit;
    assign intWake = excIn.excTaken || maskedWake;

    // ----------------------------------------------------------------
    // Sleep state machine
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_deep = deepLatched;
        case (state)
            pswc_pkg::RUN: begin
                next_deep = deepSleepSelect;
                if (coreReq.waitForInterruptInstr) begin
                    // Already-true wake condition lets execution run on
                    if (!intWake) begin
                        next_state = pswc_pkg::DOZE_INT;
                    end
                end else if (coreReq.waitForEventInstr) begin
                    if (!evtQ) begin
                        next_state = pswc_pkg::DOZE_EVT;
                    end
                end else if (coreReq.handlerDone && sleepOnExitEnable && !intWake) begin
                    next_state = pswc_pkg::DOZE_INT;
                end
            end
            pswc_pkg::DOZE_INT: begin
                if (intWake) begin
                    next_state = pswc_pkg::RUN;
                end
            end
            pswc_pkg::DOZE_EVT: begin
                // Latch may be set by a late event or a pend
                if (excIn.excTaken || evtQ) begin
                    next_state = pswc_pkg::RUN;
                end
            end
            default: begin
                next_state = pswc_pkg::RUN;
            end
        endcase
    end

    // State and the deep choice taken at entry
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= pswc_pkg::RUN;
            deepLatched <= 1'b0;
        end else begin
            state <= next_state;
            deepLatched <= next_deep;
        end
    end

    // Clock and power enables follow the next state so they align with it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwr <= '1;
            issueHold <= 1'b0;
        end else begin
            pwr.coreClkEn <= next_state == pswc_pkg::RUN;
            pwr.sysClkEn <= next_state == pswc_pkg::RUN || !next_deep;
            pwr.pllOn <= next_state == pswc_pkg::RUN || !next_deep;
            pwr.flashOn <= next_state == pswc_pkg::RUN || !next_deep;
            issueHold <= next_state != pswc_pkg::RUN;
        end
    end

    // Entry hold rises on a masked wake, drops when the mask clears
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            entryHold <= 1'b0;
        end else if (!priorityMaskBit || faultMaskBit) begin
            entryHold <= 1'b0;
        end else if (state == pswc_pkg::DOZE_INT && maskedWake) begin
            entryHold <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_core_gate;
        state != pswc_pkg::RUN |-> !pwr.coreClkEn && issueHold;
    endproperty
    a_core_gate: assert property (p_core_gate) else $error("core clock runs in sleep");

    property p_deep_off;
        state != pswc_pkg::RUN && deepLatched |-> !pwr.sysClkEn && !pwr.pllOn && !pwr.flashOn;
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("deep sleep left power on");

    property p_light_keeps;
        state != pswc_pkg::RUN && !deepLatched |-> pwr.sysClkEn && pwr.pllOn && pwr.flashOn;
    endproperty
    a_light_keeps: assert property (p_light_keeps) else $error("light sleep cut power");

    property p_int_entry;
        state == pswc_pkg::RUN && coreReq.waitForInterruptInstr && !intWake
            |=> state == pswc_pkg::DOZE_INT && deepLatched == $past(deepSleepSelect);
    endproperty
    a_int_entry: assert property (p_int_entry) else $error("no interrupt sleep");

    property p_int_skip;
        state == pswc_pkg::RUN && coreReq.waitForInterruptInstr && intWake
            |=> state == pswc_pkg::RUN && pwr.coreClkEn;
    endproperty
    a_int_skip: assert property (p_int_skip) else $error("slept with wake true");

    property p_evt_sleep;
        state == pswc_pkg::RUN && coreReq.waitForEventInstr && !evtQ
            && !coreReq.waitForInterruptInstr |=> state == pswc_pkg::DOZE_EVT;
    endproperty
    a_evt_sleep: assert property (p_evt_sleep) else $error("no event sleep");

    property p_evt_consume;
        state == pswc_pkg::RUN && coreReq.waitForEventInstr && evtQ && !evtSet
            && !coreReq.waitForInterruptInstr |=> !evtQ && state == pswc_pkg::RUN;
    endproperty
    a_evt_consume: assert property (p_evt_consume) else $error("event not consumed");

    property p_exit_sleep;
        state == pswc_pkg::RUN && coreReq == 4'h1 && sleepOnExitEnable && !intWake
            |=> state == pswc_pkg::DOZE_INT ##1 !pwr.coreClkEn;
    endproperty
    a_exit_sleep: assert property (p_exit_sleep) else $error("no sleep on exit");

    property p_int_stay;
        state == pswc_pkg::DOZE_INT && !intWake |=> state == pswc_pkg::DOZE_INT;
    endproperty
    a_int_stay: assert property (p_int_stay) else $error("spurious wake");

    property p_mask_wake;
        state == pswc_pkg::DOZE_INT && excIn.irqHigher && priorityMaskBit && !faultMaskBit
            |=> state == pswc_pkg::RUN && entryHold;
    endproperty
    a_mask_wake: assert property (p_mask_wake) else $error("masked wake wrong");

    property p_evt_exc_wake;
        state == pswc_pkg::DOZE_EVT && excIn.excTaken |=> state == pswc_pkg::RUN;
    endproperty
    a_evt_exc_wake: assert property (p_evt_exc_wake) else $error("event sleep missed exc");

    property p_pend_wake;
        state == pswc_pkg::DOZE_EVT && excIn.newPend && pendToEventEnable
            |=> ##1 state == pswc_pkg::RUN && pwr.coreClkEn;
    endproperty
    a_pend_wake: assert property (p_pend_wake) else $error("pend did not wake");

    c_deep_int: cover property (state == pswc_pkg::DOZE_INT && deepLatched ##[1:20]
        state == pswc_pkg::RUN);
    c_evt_pend: cover property (state == pswc_pkg::DOZE_EVT && pendEvt);
    c_mask_hold: cover property (entryHold ##[1:20] !entryHold);

endmodule

// [design/pswc_cfg.svh]
// Constants of the processor sleep and wake controller
//
// Behaviour
// - Light sleep gates the core clock
// - Deep sleep also stops system clock, PLL, flash
// - One control bit picks light or deep
// - Wait-for-interrupt sleeps unless wake already true
// - Wait-for-event sleeps when event latch is clear
// - Set latch: clear it and keep running
// - One-bit event latch, no software path
// - Sleep-on-exit sleeps after handler return
// - Interrupt sleep wakes on entry-worthy exception
// - Masked higher interrupt wakes, entry held off
// - Event sleep wakes on entry-worthy exception
// - Pend-to-event: any new pend wakes event sleep
`ifndef PSWC_CFG_SVH
`define PSWC_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PSWC_ADDR_W 4
`define PSWC_CTRL_OFF 4'h0
`define PSWC_STAT_OFF 4'h4

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define PSWC_CTRL_EXIT_BIT 1
`define PSWC_CTRL_DEEP_BIT 2
`define PSWC_CTRL_PEND_BIT 4
`define PSWC_CTRL_RST 1'b0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PSWC_STAT_SLEEP_BIT 0
`define PSWC_STAT_DEEP_BIT 1
`define PSWC_STAT_HOLD_BIT 2

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define PSWC_RESP_OKAY 2'h0
`define PSWC_RESP_SLVERR 2'h2

`endif

// [design/pswc_pkg.sv]
// Types of the processor sleep and wake controller
package pswc_pkg;

    // Sleep state of the core
    typedef enum logic [1:0] {
        RUN,
        DOZE_INT,
        DOZE_EVT
    } pswc_state_t;

    // Instruction and return strobes from the pipeline
    typedef struct packed {
        logic waitForInterruptInstr;
        logic waitForEventInstr;
        logic sendEventInstr;
        logic handlerDone;
    } pswc_core_req_t;

    // Conditions from the exception logic
    typedef struct packed {
        logic excTaken;
        logic irqHigher;
        logic newPend;
    } pswc_exc_t;

    // Clock and power enables
    typedef struct packed {
        logic coreClkEn;
        logic sysClkEn;
        logic pllOn;
        logic flashOn;
    } pswc_pwr_t;

endpackage

// [design/pswc_event_latch.sv]
// One-bit event latch, hidden from software
`timescale 1ns/100ps
module pswc_event_latch (
    input wire logic mclk,
    input wire logic rst,
    input wire logic setEvt,
    input wire logic clrEvt,
    output logic evtQ
);

    // ----------------------------------------------------------------
    // Latch: a set in the clearing cycle survives
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            evtQ <= 1'b0;
        end else if (setEvt) begin
            evtQ <= 1'b1;
        end else if (clrEvt) begin
            evtQ <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_set_wins;
        @(posedge mclk) disable iff (rst) setEvt |=> evtQ;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_clear_only;
        @(posedge mclk) disable iff (rst) clrEvt && !setEvt |=> !evtQ;
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("latch not cleared");

endmodule

// [design/pswc_axil_slave.sv]
// AXI4-Lite slave front end for the sleep controller registers
`timescale 1ns/100ps
`include "pswc_cfg.svh"
module pswc_axil_slave #(
    parameter int AW = `PSWC_ADDR_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wrEn,
    output logic [AW-1:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    input wire logic [31:0] rdValue,
    input wire logic rdOk
);

    logic awHeld;
    logic wHeld;
    logic next_awHeld;
    logic next_wHeld;
    logic next_bvalid;

    // Address and data are taken in either order, then applied together
    assign wrEn = awHeld && wHeld && !bvalid;
    assign next_awHeld = wrEn ? 1'b0 : (awHeld || (awvalid && awready));
    assign next_wHeld = wrEn ? 1'b0 : (wHeld || (wvalid && wready));
    assign next_bvalid = wrEn ? 1'b1 : (bvalid && !bready);

    // Write channel state; ready is registered so it drops with the hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bresp <= `PSWC_RESP_OKAY;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            bvalid <= next_bvalid;
            awready <= !next_awHeld && !next_bvalid;
            wready <= !next_wHeld && !next_bvalid;
            if (wrEn) begin
                bresp <= wrOk ? `PSWC_RESP_OKAY : `PSWC_RESP_SLVERR;
            end
        end
    end

    // Captured write payload
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrAddr <= '0;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                wrAddr <= awaddr;
            end
            if (wvalid && wready) begin
                wrData <= wdata;
                wrStrb <= wstrb;
            end
        end
    end

    // Read channel: data sampled at the address handshake
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `PSWC_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rdValue;
            rresp <= rdOk ? `PSWC_RESP_OKAY : `PSWC_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else begin
            arready <= !rvalid;
        end
    end

endmodule

// [dv/pswc_core_model.sv]
// Behavioural core pipeline and interrupt controller facing the sleep controller
`timescale 1ns/100ps
module pswc_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] cmd,
    input wire logic irqIn,
    input wire logic pendIn,
    input wire logic priorityMaskBit,
    input wire logic faultMaskBit,
    input wire logic issueHold,
    output pswc_pkg::pswc_core_req_t coreReq,
    output pswc_pkg::pswc_exc_t excIn
);
    logic pendQ;

    // Edge detect, so a held pending line counts as one new pend only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pendQ <= 1'b0;
        end else begin
            pendQ <= pendIn;
        end
    end

    // A held pipeline issues nothing, so no strobe reaches a sleeping core
    assign coreReq = pswc_pkg::pswc_core_req_t'(issueHold ? 4'h0 : cmd);
    // Entry needs both masks open; the raw level still goes to the wake logic
    assign excIn.excTaken = irqIn & ~priorityMaskBit & ~faultMaskBit;
    assign excIn.irqHigher = irqIn;
    assign excIn.newPend = pendIn & ~pendQ;
endmodule

// [dv/tb_processor_sleep_wake_control.sv]
// Self-checking testbench of the processor sleep and wake controller
`timescale 1ns/100ps
module tb_processor_sleep_wake_control;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, cmd = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic irqIn = 1'b0, pendIn = 1'b0, pmBit = 1'b0, fmBit = 1'b0, live = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, issueHold, entryHold;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    pswc_pkg::pswc_core_req_t coreReq;
    pswc_pkg::pswc_exc_t excIn;
    pswc_pkg::pswc_pwr_t pwr;
    int fails = 0, comparisons = 0, cycles = 0, seed = 32'hEE614629;
    int refState = 0, refDeep = 0, refLatch = 0, refHold = 0, refCtrl = 0;

    always #5 mclk = ~mclk;

    pswc_sleep_ctrl #(.AW(4)) DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .coreReq(coreReq), .excIn(excIn), .priorityMaskBit(pmBit),
        .faultMaskBit(fmBit), .pwr(pwr), .issueHold(issueHold), .entryHold(entryHold));

    pswc_core_model partner (.mclk(mclk), .rst(rst), .cmd(cmd), .irqIn(irqIn),
        .pendIn(pendIn), .priorityMaskBit(pmBit), .faultMaskBit(fmBit),
        .issueHold(issueHold), .coreReq(coreReq), .excIn(excIn));

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    // Sees only what the design sees at its inputs, never its outputs
    always @(posedge mclk or posedge rst) begin
        int wake;
        if (rst) begin
            refState = 0;
            refLatch = 0;
            refHold = 0;
        end else begin
            wake = excIn.excTaken | (excIn.irqHigher & pmBit & ~fmBit);
            if (refHold && (!pmBit || fmBit)) refHold = 0;
            if (refState == 0) begin
                if (coreReq.waitForInterruptInstr) begin
                    if (!wake) refState = 1;
                end else if (coreReq.waitForEventInstr) begin
                    if (refLatch == 0) refState = 2;
                    else refLatch = 0;
                end else if (coreReq.handlerDone && refCtrl[1] && !wake) begin
                    refState = 1;
                end
                refDeep = refCtrl[2];
            end else if (refState == 1) begin
                if (wake) begin
                    refHold = !excIn.excTaken;
                    refState = 0;
                end
            end else if (excIn.excTaken || refLatch) begin
                refLatch = 0;
                refState = 0;
            end
            // Set is applied last so it wins over a clear in the same cycle
            if (coreReq.sendEventInstr || (excIn.newPend && refCtrl[4])) refLatch = 1;
        end
    end

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task conclude();
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Outputs are settled by the falling edge, so compare there every cycle
    always @(negedge mclk) begin
        logic [5:0] expOut;
        expOut = {(refState == 0) ? 4'hF : (refDeep != 0 ? 4'h0 : 4'h7), refState != 0,
            refHold != 0};
        if (live) chk({26'h0, pwr, issueHold, entryHold}, {26'h0, expOut});
    end

    // Hang guard, far above the roughly 150 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // Bus and core drivers
    // ----------------------------------------------------------------
    // Address and data offered together, each dropped at its own handshake
    task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        if (a == 4'h0 && bresp === 2'h0) refCtrl = d;
    endtask

    task automatic axiRd(input logic [3:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // One-cycle instruction strobe, then n idle cycles
    task automatic op(input logic [3:0] c, input int n);
        @(posedge mclk);
        cmd <= c;
        @(posedge mclk);
        cmd <= 4'h0;
        repeat (n) @(posedge mclk);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        live = 1'b1;
        axiRd(4'h0);
        chk(rd, 32'h0);
        axiRd(4'h8);
        chk({30'h0, resp}, 32'h2);
        axiWr(4'h8, $random(seed));
        chk({30'h0, resp}, 32'h2);
        axiWr(4'h4, $random(seed));
        chk({30'h0, resp}, 32'h0);
        // Light sleep, then wait-for-interrupt with a wake already pending
        op(4'h1, 2);
        op(4'h8, 3);
        @(posedge mclk) irqIn <= 1'b1;
        op(4'h8, 2);
        @(posedge mclk) irqIn <= 1'b0;
        // Deep sleep; a later change of the select bit waits for the next entry
        axiWr(4'h0, 32'h4);
        op(4'h8, 2);
        axiRd(4'h4);
        chk(rd, 32'h3);
        axiWr(4'h0, 32'h0);
        @(posedge mclk) irqIn <= 1'b1;
        @(posedge mclk) irqIn <= 1'b0;
        // Event sleep, and a set latch that is consumed instead of sleeping
        op(4'h4, 3);
        @(posedge mclk) irqIn <= 1'b1;
        @(posedge mclk) irqIn <= 1'b0;
        op(4'h2, 0);
        axiRd(4'h4);
        chk(rd, 32'h0);
        op(4'h4, 2);
        op(4'h4, 2);
        @(posedge mclk) irqIn <= 1'b1;
        @(posedge mclk) irqIn <= 1'b0;
        // Sleep on handler return
        axiWr(4'h0, 32'h2);
        op(4'h1, 3);
        @(posedge mclk) irqIn <= 1'b1;
        @(posedge mclk) irqIn <= 1'b0;
        // Fault mask blocks the masked wake; priority mask alone holds entry
        pmBit <= 1'b1;
        fmBit <= 1'b1;
        op(4'h8, 1);
        @(posedge mclk) irqIn <= 1'b1;
        op(4'h0, 3);
        fmBit <= 1'b0;
        op(4'h0, 2);
        axiRd(4'h4);
        chk(rd, 32'h4);
        pmBit <= 1'b0;
        op(4'h0, 2);
        irqIn <= 1'b0;
        // A new pend wakes event sleep only with the pend enable set
        axiWr(4'h0, 32'h10);
        op(4'h4, 2);
        pendIn <= 1'b1;
        op(4'h0, 3);
        pendIn <= 1'b0;
        axiWr(4'h0, 32'h0);
        op(4'h4, 2);
        pendIn <= 1'b1;
        op(4'h0, 3);
        pendIn <= 1'b0;
        @(posedge mclk) irqIn <= 1'b1;
        @(posedge mclk) irqIn <= 1'b0;
        op(4'h0, 2);
        conclude();
    end
endmodule
